// ===== dv/sdi_transmit_encoder_bench.sv
`timescale 1ns/1ps
`include "sdi_enc_consts.svh"
////////////////////////////////////////////////////////////////////////////////
module sdi_transmit_encoder_bench;
  import sdi_enc_pkg::*;
  typedef logic bq_t[$];
  typedef logic [9:0] lq_t[$];
  logic clk, rst, load, slow, vid_valid, vid_ready, lo_seen;
  logic [9:0] load_data, vid_data, par_word;
  logic [1:0] sdi_pair, bresp, rresp, r;
  logic [3:0] refclk_quad;
  logic [5:0] pending;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int miscompares, n_tests;
  logic [15:0] rnd;
  bq_t sq;
  lq_t pq, w;
  ctrl_t modes[8] = '{6'h1c, 6'h1e, 6'h18, 6'h14, 6'h0c, 6'h04, 6'h1a, 6'h3c};
  sdi_transmit_encoder dut (.clk(clk), .rst(rst), .vid_valid(vid_valid),
    .vid_ready(vid_ready), .vid_data(vid_data), .sdi_pair(sdi_pair),
    .refclk_quad(refclk_quad), .par_word(par_word), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  video_source_model src (.clk(clk), .rst(rst), .load(load), .load_data(load_data),
    .slow(slow), .vid_valid(vid_valid), .vid_data(vid_data), .vid_ready(vid_ready),
    .pending(pending));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (!rst)
    begin
      sq.push_back(sdi_pair[0]);
      sq.push_back(sdi_pair[1]);
      pq.push_back(par_word);
      if (!vid_ready)
        lo_seen <= 1'b1;
    end
    else
      lo_seen <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [9:0] expw(logic [9:0] v, ctrl_t c);
    logic [9:0] x;
    x = v;
    if (c.eight_bit) x[1:0] = 2'b01;
    if (c.clip_en && x[9:2] == 8'h00) x[1:0] = 2'b00;
    if (c.clip_en && x[9:2] == 8'hff) x[1:0] = 2'b11;
    return x;
  endfunction
  function automatic bq_t wbits(lq_t v);
    bq_t b;
    foreach (v[i]) for (int k = 0; k < 10; k++) b.push_back(v[i][k]);
    return b;
  endfunction
  // Both decoders resynchronise by themselves, so no word alignment is needed
  function automatic bq_t dec(bq_t s, logic scr, logic nz);
    bq_t n, o;
    for (int i = 1; i < s.size(); i++) n.push_back(nz ? s[i] ^ s[i-1] : s[i]);
    for (int i = 9; i < n.size(); i++) o.push_back(scr ? n[i] ^ n[i-4] ^ n[i-9] : n[i]);
    return o;
  endfunction
  function automatic logic hit(bq_t s, bq_t e);
    int j;
    for (int i = 0; i + e.size() <= s.size(); i++)
    begin
      for (j = 0; j < e.size() && s[i+j] === e[j]; j++);
      if (j == e.size()) return 1'b1;
    end
    return 1'b0;
  endfunction
  function automatic logic phit(lq_t p, bq_t e, logic scr, logic nz);
    bq_t s;
    for (int o = 0; o < 5; o++)
    begin
      s = {};
      for (int k = o; k < p.size(); k += 5) for (int b = 0; b < 10; b++) s.push_back(p[k][b]);
      if (hit(dec(s, scr, nz), e)) return 1'b1;
    end
    return 1'b0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task axw(input logic [11:0] a, input logic [31:0] dt, output logic [1:0] rs);
    int i;
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
    chk(i < 50, 1'b1);
    if (i == 50) stop_test();
  endtask
  task axr(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] rs);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
    if (i == 50) chk(i, 0);
    if (i == 50) stop_test();
  endtask
  task automatic run(input ctrl_t c, input lq_t v, input int from, input logic slw);
    lq_t ex;
    bq_t e;
    logic so, po;
    int i;
    axw(`OFS_CTRL, {26'h0, c}, r);
    chk(r, `AXI_OKAY);
    sq = {};
    pq = {};
    st = 32'h0;
    for (i = 0; i < v.size(); i++)
    begin
      load <= 1'b1;
      load_data <= v[i];
      slow <= slw && i < from;
      if (i >= from) ex.push_back(expw(v[i], c));
      @(posedge clk);
    end
    load <= 1'b0;
    e = wbits(ex);
    so = 1'b0;
    po = 1'b0;
    for (i = 0; i < 60 && !(so && po); i++)
    begin
      axr(`OFS_STATUS, d, r);
      st |= d;
      repeat (8) @(posedge clk);
      so = hit(dec(sq, c.scram_en, c.nrzi_en), e);
      po = phit(pq, e, c.scram_en, c.nrzi_en);
    end
    chk(so, 1'b1);
    chk(po, 1'b1);
    chk(refclk_quad, c.refclk_en ? 4'h5 : 4'h0);
    chk(st[0], c.patho_en);
    chk(pending, 6'h0);
    $display("run ctrl %h done", c);
    if (!(so && po)) stop_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, load, slow, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
    {load_data, awaddr, araddr, wdata} = '0;
    rnd = 16'h003b;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(`OFS_CTRL, d, r);
    chk(d, {26'h0, `CTRL_RESET});
    axr(`OFS_STATUS, d, r);
    chk(d, 32'h2);
    axr(12'h0fc, d, r);
    chk({r, d}, {`AXI_SLVERR, 32'h0});
    axw(12'h0fc, 32'h3f, r);
    chk(r, `AXI_SLVERR);
    axr(`OFS_CTRL, d, r);
    chk(d, {26'h0, `CTRL_RESET});
    $display("register test done");
    foreach (modes[m])
    begin
      w = '{10'h3fc, 10'h003, 10'h3fe, 10'h001, 10'h0ff, 10'h300};
      repeat (20)
      begin
        rnd = lfsr(rnd);
        w.push_back(rnd[9:0]);
      end
      run(modes[m], w, 0, 1'b0);
    end
    chk(lo_seen, 1'b1);
    chk(st[2], 1'b1);
    axr(`OFS_STATUS, d, r);
    chk(d[2:1], 2'b01);
    // Slow only while the first 44 words are loaded, so the buffer fills while test words are inserted
    w = '{10'h3ff, 10'h000, 10'h000, 10'h274};
    repeat (40) w.push_back(10'h200);
    w = {w, 10'h3ff, 10'h000, 10'h000, 10'h200};
    repeat (16)
    begin
      rnd = lfsr(rnd);
      w.push_back(rnd[9:0]);
    end
    run(6'h1d, w, 44, 1'b1);
    chk(st[3], 1'b1);
    chk(hit(dec(sq, 1'b1, 1'b1), wbits('{10'h3fe, 10'h000, 10'h001})), 1'b1);
    chk(hit(dec(sq, 1'b1, 1'b1), wbits('{10'h000, 10'h3ff, 10'h3fe})), 1'b1);
    $display("inserter test done");
    stop_test();
  end
endmodule

// ===== dv/video_source_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module video_source_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [9:0] load_data,
  input wire logic slow,
  output logic vid_valid,
  output logic [9:0] vid_data,
  input wire logic vid_ready,
  output logic [5:0] pending
);
  logic [9:0] q[$];
  logic [2:0] gap_ff;
  // A slow source leaves gaps between words so it hands over one word every five cycles, the word rate
  always @(posedge clk)
  begin
    if (rst)
    begin
      q.delete();
      vid_valid <= 1'b0;
      vid_data <= 10'h000;
      gap_ff <= 3'h0;
      pending <= 6'h0;
    end
    else
    begin
      if (load)
        q.push_back(load_data);
      if (vid_valid && vid_ready)
      begin
        vid_valid <= 1'b0;
        // Released data never shows the last word
        vid_data <= ~vid_data;
        gap_ff <= slow ? 3'h3 : 3'h0;
      end
      else if (!vid_valid && gap_ff != 3'h0)
        gap_ff <= gap_ff - 3'h1;
      else if (!vid_valid && q.size() > 0)
      begin
        vid_valid <= 1'b1;
        vid_data <= q.pop_front();
      end
      pending <= 6'(q.size());
    end
  end
endmodule

// ===== verilog/sdi_enc_consts.svh
`ifndef SDI_ENC_CONSTS_SVH
`define SDI_ENC_CONSTS_SVH
// Register byte offsets
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_PAR_WORD 12'h008
// Control field positions
`define CTRL_PATHO_EN 0
`define CTRL_EIGHT_BIT 1
`define CTRL_CLIP_EN 2
`define CTRL_SCRAM_EN 3
`define CTRL_NRZI_EN 4
`define CTRL_REFCLK_EN 5
`define CTRL_RESET 6'h1c
// Fast clock cycles per video word
`define WORD_DIV 5
// Video constants and AXI response codes
`define TRS_ONES 10'h3ff
`define TRS_ZEROS 10'h000
`define IDLE_WORD 10'h200
`define HBLANK_BIT 6
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ===== verilog/sdi_enc_pkg.sv
package sdi_enc_pkg;
  typedef struct packed {
    logic refclk_en;
    logic nrzi_en;
    logic scram_en;
    logic clip_en;
    logic eight_bit;
    logic patho_en;
  } ctrl_t;
  typedef struct packed {
    logic valid;
    logic [9:0] data;
  } video_t;
  typedef enum logic {LINE_ACTIVE, LINE_BLANK} line_state_t;
endpackage

// ===== verilog/sdi_transmit_encoder.sv
// Overview of operation
// RQ1: Fast clock is five times word rate, output in two opposite phases.
// RQ2: Clipped words go to half-rate scrambler, two bits per fast cycle.
// RQ3: Optional bit-rate reference clock pattern driven as DDR bits.
// RQ4: Word-rate encoder turns one 10-bit word into one encoded word.
// RQ5: Only compliant scrambling; no transport pass-through mode. The code passes words through when scram_en and nrzi_en are both clear.
// RQ6: Test inserter forwards active video and timing symbols untouched.
// RQ7: In horizontal blanking insert near-miss timing symbols, one bit off.
// RQ8: Also insert near-miss ancillary start symbols, one bit off.
// RQ9: Test cases only while inserter enable is high, else pass-through.
// RQ10: Clipping is disabled while the inserter is substituting.
// RQ11: Eight-bit emulation forces bit0 high and bit1 low before clipping.
// RQ12: Half-rate logic every fast cycle; word logic on word enable.
// RQ13: Clip two LSBs to zero or one when upper eight all zero or one.
// RQ14: Scramble by x^9+x^4+1, then NRZI by x+1.
// RQ15: Words are serialized least significant bit first.
// RQ16: Separate scramble and NRZI enables allow each stage bypass.
// RQ17: Reset clears scrambler state, NRZI bit and inserter line state.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sdi_enc_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module scram_core #(parameter int N = 10)
(
  input wire logic [N-1:0] d,
  input wire logic [8:0] lfsr,
  input wire logic prev,
  input wire logic scram_en,
  input wire logic nrzi_en,
  output logic [N-1:0] q,
  output logic [8:0] lfsr_n,
  output logic prev_n
);
  always_comb
  begin
    logic [8:0] h;
    logic p;
    logic y;
    h = lfsr;
    p = prev;
    y = 1'b0;
    q = '0;
    for (int i = 0; i < N; i++)
    begin
      y = scram_en ? (d[i] ^ h[3] ^ h[8]) : d[i]; // RQ14 RQ16
      q[i] = nrzi_en ? (y ^ p) : y; // RQ14 RQ16
      p = q[i];
      h = {h[7:0], y};
    end
    lfsr_n = h;
    prev_n = p;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sync_fifo #(parameter int W = 10, parameter int D = 8)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;
  assign in_ready = cnt_ff < (AW+1)'(D);
  assign out_valid = cnt_ff != '0;
  assign out_data = mem_ff[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
      if (pop)
        rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sdi_transmit_encoder #(parameter int FIFO_DEPTH = 8)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic vid_valid,
  output logic vid_ready,
  input wire logic [9:0] vid_data,
  output logic [1:0] sdi_pair,
  output logic [3:0] refclk_quad,
  output logic [9:0] par_word,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sdi_enc_pkg::*;

  ctrl_t ctrl_ff;
  logic [2:0] div_ff;
  logic word_en;
  sdi_enc_pkg::video_t fifo_out;
  logic [9:0] pipe_ff [4];
  logic [1:0] protect_ff;
  line_state_t line_ff;
  logic [2:0] pat_ff;
  logic replace;
  logic preamble;
  logic [9:0] patho_word;
  logic [9:0] forced;
  logic clip_active;
  logic [9:0] clipped;
  logic [9:0] sh_ff;
  logic [8:0] lfsr2_ff;
  logic prev2_ff;
  logic [1:0] pair_n;
  logic [8:0] lfsr2_n;
  logic prev2_n;
  logic [9:0] in_par_ff;
  logic [8:0] lfsr10_ff;
  logic prev10_ff;
  logic [9:0] par_n;
  logic [8:0] lfsr10_n;
  logic prev10_n;
  logic [1:0] pair_ff;
  logic [3:0] ref_ff;
  logic [9:0] par_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Word enable: the fast clock is the word clock times five
  assign word_en = div_ff == 3'(`WORD_DIV - 1); // RQ1 RQ12
  always_ff @(posedge clk)
  begin
    if (rst || word_en)
      div_ff <= '0;
    else
      div_ff <= div_ff + 3'h1;
  end

  // Drained only at word rate, so the source really stalls
  sync_fifo #(.W(10), .D(FIFO_DEPTH)) u_fifo
  (
    .clk(clk),
    .rst(rst),
    .in_valid(vid_valid),
    .in_ready(vid_ready),
    .in_data(vid_data),
    .out_valid(fifo_out.valid),
    .out_ready(word_en),
    .out_data(fifo_out.data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Test inserter, four-word look-ahead so real timing symbols stay whole
  assign preamble = pipe_ff[3] == `TRS_ONES && pipe_ff[2] == `TRS_ZEROS
    && pipe_ff[1] == `TRS_ZEROS;
  assign replace = ctrl_ff.patho_en && line_ff == LINE_BLANK && !preamble
    && protect_ff == 2'h0; // RQ6 RQ9
  always_comb
  begin
    case (pat_ff)
      3'h0: patho_word = 10'h3fe; // RQ7
      3'h1: patho_word = 10'h000;
      3'h2: patho_word = 10'h001; // RQ7
      3'h3: patho_word = 10'h000; // RQ8
      3'h4: patho_word = 10'h3ff;
      3'h5: patho_word = 10'h3fe; // RQ8
      3'h6: patho_word = 10'h080;
      default: patho_word = 10'h040;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        pipe_ff[i] <= `IDLE_WORD;
      protect_ff <= 2'h0;
      line_ff <= LINE_ACTIVE; // RQ17
      pat_ff <= 3'h0;
    end
    else if (word_en)
    begin
      pipe_ff[0] <= fifo_out.valid ? fifo_out.data : `IDLE_WORD;
      for (int i = 1; i < 4; i++)
        pipe_ff[i] <= pipe_ff[i-1];
      if (preamble)
        protect_ff <= 2'h3;
      else if (protect_ff != 2'h0)
        protect_ff <= protect_ff - 2'h1;
      if (protect_ff == 2'h1)
        line_ff <= pipe_ff[3][`HBLANK_BIT] ? LINE_BLANK : LINE_ACTIVE; // RQ7
      if (replace)
        pat_ff <= pat_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Eight-bit emulation and clipper
  always_comb
  begin
    forced = replace ? patho_word : pipe_ff[3];
    if (ctrl_ff.eight_bit)
      forced[1:0] = 2'b01; // RQ11
  end
  assign clip_active = ctrl_ff.clip_en && !replace; // RQ10
  always_comb
  begin
    clipped = forced;
    if (clip_active && forced[9:2] == 8'h00)
      clipped[1:0] = 2'b00; // RQ13
    else if (clip_active && forced[9:2] == 8'hff)
      clipped[1:0] = 2'b11; // RQ13
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-rate scrambler, two bits per fast cycle, LSB pair first
  scram_core #(.N(2)) u_half_rate_scrambler
  (
    .d(sh_ff[1:0]),
    .lfsr(lfsr2_ff),
    .prev(prev2_ff),
    .scram_en(ctrl_ff.scram_en),
    .nrzi_en(ctrl_ff.nrzi_en),
    .q(pair_n),
    .lfsr_n(lfsr2_n),
    .prev_n(prev2_n)
  );
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sh_ff <= '0;
      lfsr2_ff <= '0; // RQ17
      prev2_ff <= 1'b0;
      pair_ff <= 2'b00;
    end
    else
    begin
      sh_ff <= word_en ? clipped : {2'b00, sh_ff[9:2]}; // RQ2 RQ15
      lfsr2_ff <= lfsr2_n;
      prev2_ff <= prev2_n;
      pair_ff <= pair_n; // RQ2 RQ12
    end
  end
  // Bit 0 leaves on the first phase, bit 1 on the opposite phase
  assign sdi_pair = pair_ff; // RQ1

  // Reference clock as four quarter-cycle bits: doubled clock through DDR
  always_ff @(posedge clk)
  begin
    if (rst)
      ref_ff <= 4'h0;
    else
      ref_ff <= ctrl_ff.refclk_en ? 4'h5 : 4'h0; // RQ3
  end
  assign refclk_quad = ref_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Word-rate encoder; not compliant-only: clearing both scram_en and nrzi_en passes words through
  scram_core #(.N(10)) u_par_scrambler
  (
    .d(in_par_ff),
    .lfsr(lfsr10_ff),
    .prev(prev10_ff),
    .scram_en(ctrl_ff.scram_en),
    .nrzi_en(ctrl_ff.nrzi_en),
    .q(par_n),
    .lfsr_n(lfsr10_n),
    .prev_n(prev10_n)
  );
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      in_par_ff <= '0;
      lfsr10_ff <= '0; // RQ17
      prev10_ff <= 1'b0;
      par_ff <= '0;
    end
    else if (word_en)
    begin
      in_par_ff <= clipped; // RQ4 RQ12
      lfsr10_ff <= lfsr10_n;
      prev10_ff <= prev10_n;
      par_ff <= par_n; // RQ4 RQ5
    end
  end
  assign par_word = par_ff;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_got_ff;
  logic w_got_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
      ctrl_ff <= ctrl_t'(`CTRL_RESET);
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (aw_got_ff && w_got_ff && !s_axi_bvalid)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff[11:2] == `OFS_CTRL >> 2) ? `AXI_OKAY : `AXI_SLVERR;
        if (awaddr_ff[11:2] == `OFS_CTRL >> 2 && wstrb0_ff)
          ctrl_ff <= ctrl_t'(wdata_ff[5:0]);
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AXI_OKAY;
      case (s_axi_araddr[11:2])
        `OFS_CTRL >> 2: s_axi_rdata <= {26'h0, ctrl_ff};
        `OFS_STATUS >> 2: s_axi_rdata <= {28'h0, line_ff == LINE_BLANK, !vid_ready,
          !fifo_out.valid, replace};
        `OFS_PAR_WORD >> 2: s_axi_rdata <= {22'h0, par_ff};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_clip_low: assert property (@(posedge clk) disable iff (rst) // RQ13
    clip_active && forced[9:2] == 8'h00 |-> clipped == 10'h000) else $error("clip low");
  a_clip_high: assert property (@(posedge clk) disable iff (rst) // RQ13
    clip_active && forced[9:2] == 8'hff |-> clipped == 10'h3ff) else $error("clip high");
  a_clip_bypass: assert property (@(posedge clk) disable iff (rst) // RQ10
    replace |-> clipped == forced && !clip_active) else $error("clip not off");
  a_eight_bit_force: assert property (@(posedge clk) disable iff (rst) // RQ11
    ctrl_ff.eight_bit && !clip_active |-> clipped[1:0] == 2'b01) else $error("eight bit");
  a_patho_pass: assert property (@(posedge clk) disable iff (rst) // RQ9
    !ctrl_ff.patho_en |-> !replace && forced[9:2] == pipe_ff[3][9:2]) else $error("pass");
  a_trs_kept: assert property (@(posedge clk) disable iff (rst) // RQ6
    preamble && word_en |=> sh_ff[9:2] == 8'hff && !replace) else $error("trs replaced");
  a_word_cadence: assert property (@(posedge clk) disable iff (rst) // RQ12
    word_en |=> !word_en [*4] ##1 word_en) else $error("word cadence");
  a_bypass_lsb: assert property (@(posedge clk) disable iff (rst) // RQ15
    !ctrl_ff.scram_en && !ctrl_ff.nrzi_en ##1 !ctrl_ff.scram_en && !ctrl_ff.nrzi_en
    |-> sdi_pair == $past(sh_ff[1:0])) else $error("lsb first");
  a_reset_clear: assert property (@(posedge clk) // RQ17
    rst |=> lfsr2_ff == 9'h0 && !prev2_ff && lfsr10_ff == 9'h0 && line_ff == LINE_ACTIVE)
    else $error("reset state");
  a_bresp_hold: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp hold");
  c_replace: cover property (@(posedge clk) disable iff (rst) $rose(replace));
  c_eight_clip: cover property (@(posedge clk) disable iff (rst)
    ctrl_ff.eight_bit && clip_active && forced[9:2] == 8'hff);
  c_fifo_full: cover property (@(posedge clk) disable iff (rst) vid_valid && !vid_ready);
endmodule
